// ==== ucv_defs.vh ====
// Register map, field positions, reset values and commands of the serial channel block.
//
// Contract
// - On interrupt acknowledge the channel drives a vector byte on the data lines in formats 00, 01 and 10.
// - Every acknowledge cycle ends with a low pulse on the transfer acknowledge output.
// - Vector format 00 returns the whole programmed vector register.
// - Format 01 returns vector bits 7:2 above the two-bit channel number.
// - Format 10 returns vector bits 7:5, three-bit type, then channel number.
// - Format 11 drives no vector; data bus stays released all cycle.
// - Transfer acknowledge pulse is produced even when no vector is driven.
// - Mode zero bit 7 enables receive watchdog; low four bits reserved.
// - Character length codes 00..11 select 5, 6, 7 or 8 data bits.
// - Parity mode with, forced, none, wake-up; parity type even or odd.
// - Block error mode keeps errors until error reset or receiver reset.
// - Channel mode selects normal, auto echo, local loop or remote loop.
// - With five-bit characters, stop codes 0..7 add half a bit.
// - Command bit 3/2 disable/enable transmitter, bit 1/0 receiver; upper nibble misc.
// - A disabled transmitter accepts no characters.
// - Status bits 7:5 follow FIFO top; block mode holds them until reset.
// - Auxiliary control bit 7 selects the first or second baud rate set.
// - Receiver bids only at fill level 1+, 3+, 6+ or 8 bytes.
// - Transmitter bids only at 8, 4+, 6+ or 1+ free positions.
// - Mode pointer advances on each mode access and sticks at two.
`ifndef UCV_DEFS_VH
`define UCV_DEFS_VH

// APB byte addresses.
`define UCV_A_MODE        8'h00
`define UCV_A_CLKSEL      8'h04
`define UCV_A_CMD_STAT    8'h08
`define UCV_A_TXD_RXD     8'h0c
`define UCV_A_AUX         8'h10
`define UCV_A_IRQ_CTRL    8'h14
`define UCV_A_VECTOR      8'h18
`define UCV_A_CUR_IRQ     8'h1c
`define UCV_A_FMT         8'h20

// Reset values.
`define UCV_R_VECTOR      8'h0f
`define UCV_R_CUR_IRQ     8'hff

// Mode zero fields.
`define UCV_M0_WDOG       7
`define UCV_M0_RX_HI      6
`define UCV_M0_TXSEL_HI   5
`define UCV_M0_TXSEL_LO   4
`define UCV_M0_RSVD_RD    4'hf

// Mode one fields.
`define UCV_M1_ERRMODE    5

// Mode two fields.
`define UCV_M2_CTS_EN     4

// Auxiliary control field.
`define UCV_AUX_BRG_SET   7

// Command codes in the upper nibble.
`define UCV_C_RST_PTR     4'h1
`define UCV_C_RST_RX      4'h2
`define UCV_C_RST_TX      4'h3
`define UCV_C_RST_ERR     4'h4
`define UCV_C_UPD_CIR     4'h9
`define UCV_C_PTR_ZERO    4'hb

// Vector formats.
`define UCV_VF_FULL       2'b00
`define UCV_VF_CHAN       2'b01
`define UCV_VF_TYPE       2'b10
`define UCV_VF_NONE       2'b11

// FIFO depth.
`define UCV_FIFO_DEPTH    8

// Acknowledge pulse width in ns and cycles at 8 ns.
`define UCV_ACK_NS        16
`define UCV_CLK_NS        8
`define UCV_ACK_CYC       ((`UCV_ACK_NS + `UCV_CLK_NS - 1) / `UCV_CLK_NS)

`endif

// ==== ucv_channel.v ====
// One serial channel: configuration, command, status, FIFOs and interrupt vector.
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "ucv_defs.vh"

module ucv_channel #(
    parameter [1:0] CHAN_NUM = 2'd0,
    parameter       DEPTH    = `UCV_FIFO_DEPTH
) (
    // Clock, reset, enable
    input  wire        core_clk,
    input  wire        reset,
    input  wire        clk_en,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Host acknowledge pins
    input  wire        int_ack_in_n,
    output reg         xfer_ack_out_n,
    output reg  [7:0]  data_out,
    output reg         data_oe,
    // Line side (serial engine outside)
    input  wire        cts_in_n,
    input  wire        rx_char_valid,
    input  wire [7:0]  rx_char,
    input  wire [2:0]  rx_char_err,
    input  wire        tx_char_ready,
    output wire        tx_char_valid,
    output wire [7:0]  tx_char,
    // Configuration decoded for the serial engine
    output reg  [3:0]  data_bits,
    output wire [1:0]  parity_mode,
    output wire        parity_odd,
    output wire [1:0]  channel_mode,
    output reg  [5:0]  stop_sixteenths,
    output wire        watchdog_en,
    output wire        baud_set2,
    output wire [7:0]  rx_tx_clock_select,
    output reg         rx_enabled,
    output reg         tx_enabled,
    output wire        rx_bid,
    output wire        tx_bid
);

    ////////////////////////////////////////////////////////////////////////
    // Registers.
    reg  [7:0] mode_zero_watchdog_fill;
    reg  [7:0] mode_one_char_format;
    reg  [7:0] mode_two_channel_stop;
    reg  [7:0] clksel_q;
    reg  [7:0] auxiliary_control;
    reg  [7:0] irq_control_reg;
    reg  [7:0] vector_base_reg;
    reg  [7:0] current_irq_latch;
    reg  [1:0] mode_ptr_q;
    reg  [7:0] rx_mem [0:DEPTH-1];
    reg  [2:0] rx_err_mem [0:DEPTH-1];
    reg  [7:0] tx_mem [0:DEPTH-1];
    reg  [3:0] rx_cnt_q;
    reg  [2:0] rx_rd_q;
    reg  [2:0] rx_wr_q;
    reg  [3:0] tx_cnt_q;
    reg  [2:0] tx_rd_q;
    reg  [2:0] tx_wr_q;
    reg  [2:0] blk_err_q;
    reg        overrun_q;
    reg  [2:0] ack_sync_q;
    reg  [2:0] cts_sync_q;
    reg  [1:0] ack_st_q;
    reg  [1:0] ack_cnt_q;

    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_ACK  = 2'b10;

    wire       wr_acc = psel & penable & pwrite;
    wire       rd_acc = psel & penable & ~pwrite;
    wire [7:0] wd     = pwdata[7:0];
    wire [3:0] cmd    = wd[7:4];
    wire       cmd_wr = wr_acc & (paddr == `UCV_A_CMD_STAT);
    wire       mode_acc = psel & penable & (paddr == `UCV_A_MODE);
    wire       rx_pop = rd_acc & (paddr == `UCV_A_TXD_RXD) & (rx_cnt_q != 4'd0);
    wire       rx_rst = cmd_wr & (cmd == `UCV_C_RST_RX);
    wire       tx_rst = cmd_wr & (cmd == `UCV_C_RST_TX);
    wire       rx_push = rx_char_valid & rx_enabled & (rx_cnt_q != DEPTH);
    wire       tx_push = wr_acc & (paddr == `UCV_A_TXD_RXD) & tx_enabled
                         & (tx_cnt_q != DEPTH);
    wire       cts_ok  = ~mode_two_channel_stop[`UCV_M2_CTS_EN]
                         | (~cts_sync_q[1] & ~cts_sync_q[2]);
    wire       tx_pop  = tx_char_valid & tx_char_ready;
    wire       blk_mode = mode_one_char_format[`UCV_M1_ERRMODE];
    wire [2:0] top_err = (rx_cnt_q != 4'd0) ? rx_err_mem[rx_rd_q] : 3'b000;
    wire [3:0] tx_free = DEPTH[3:0] - tx_cnt_q;
    wire       ack_fall = ~ack_sync_q[2] & ~ack_sync_q[1];

    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign tx_char_valid = (tx_cnt_q != 4'd0) & tx_enabled & cts_ok;
    assign tx_char = tx_mem[tx_rd_q];
    assign parity_mode  = mode_one_char_format[4:3];
    assign parity_odd   = mode_one_char_format[2];
    assign channel_mode = mode_two_channel_stop[7:6];
    assign watchdog_en  = mode_zero_watchdog_fill[`UCV_M0_WDOG];
    assign baud_set2    = auxiliary_control[`UCV_AUX_BRG_SET];
    assign rx_tx_clock_select = clksel_q;

    ////////////////////////////////////////////////////////////////////////
    // Decoded character format.
    always @* begin
        data_bits = 4'd5 + {2'b00, mode_one_char_format[1:0]};
        stop_sixteenths = 6'd9 + {2'b00, mode_two_channel_stop[3:0]};
        if (mode_two_channel_stop[3:0] > 4'h7)
            stop_sixteenths = stop_sixteenths + 6'd8;
        if (mode_one_char_format[1:0] == 2'b00 && !mode_two_channel_stop[3])
            stop_sixteenths = stop_sixteenths + 6'd8;
    end

    // Fill-level bids.
    reg rx_bid_r;
    reg tx_bid_r;
    always @* begin
        case ({mode_zero_watchdog_fill[`UCV_M0_RX_HI], mode_one_char_format[6]})
            2'b00:   rx_bid_r = rx_cnt_q >= 4'd1;
            2'b01:   rx_bid_r = rx_cnt_q >= 4'd3;
            2'b10:   rx_bid_r = rx_cnt_q >= 4'd6;
            default: rx_bid_r = rx_cnt_q == 4'd8;
        endcase
        case (mode_zero_watchdog_fill[5:4])
            2'b00:   tx_bid_r = tx_free == 4'd8;
            2'b01:   tx_bid_r = tx_free >= 4'd4;
            2'b10:   tx_bid_r = tx_free >= 4'd6;
            default: tx_bid_r = tx_free >= 4'd1;
        endcase
    end
    assign rx_bid = rx_bid_r & rx_enabled;
    assign tx_bid = tx_bid_r & tx_enabled;

    ////////////////////////////////////////////////////////////////////////
    // Read data.
    wire [7:0] status = {top_err | blk_err_q, overrun_q,
                         (tx_cnt_q == 4'd0), (tx_cnt_q != DEPTH),
                         (rx_cnt_q == DEPTH), (rx_cnt_q != 4'd0)};
    reg  [7:0] rd_byte;
    always @* begin
        case (paddr)
            `UCV_A_MODE: begin
                case (mode_ptr_q)
                    2'd0:    rd_byte = {mode_zero_watchdog_fill[7:4], `UCV_M0_RSVD_RD};
                    2'd1:    rd_byte = mode_one_char_format;
                    default: rd_byte = mode_two_channel_stop;
                endcase
            end
            `UCV_A_CLKSEL:   rd_byte = clksel_q;
            `UCV_A_CMD_STAT: rd_byte = status;
            `UCV_A_TXD_RXD:  rd_byte = rx_mem[rx_rd_q];
            `UCV_A_AUX:      rd_byte = auxiliary_control;
            `UCV_A_IRQ_CTRL: rd_byte = irq_control_reg;
            `UCV_A_VECTOR:   rd_byte = vector_base_reg;
            `UCV_A_CUR_IRQ:  rd_byte = current_irq_latch;
            `UCV_A_FMT:      rd_byte = {tx_enabled, rx_enabled, 6'h00};
            default:         rd_byte = 8'h00;
        endcase
    end

    // Vector byte selected by the format field.
    reg [7:0] vec;
    always @* begin
        case (irq_control_reg[1:0])
            `UCV_VF_FULL: vec = vector_base_reg;
            `UCV_VF_CHAN: vec = {vector_base_reg[7:2], current_irq_latch[1:0]};
            `UCV_VF_TYPE: vec = {vector_base_reg[7:5], current_irq_latch[4:2],
                                 current_irq_latch[1:0]};
            default:      vec = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequential logic.
    always @(posedge core_clk) begin
        if (reset) begin
            mode_zero_watchdog_fill <= 8'h00;
            mode_one_char_format    <= 8'h00;
            mode_two_channel_stop   <= 8'h00;
            clksel_q          <= 8'h00;
            auxiliary_control <= 8'h00;
            irq_control_reg   <= 8'h00;
            vector_base_reg   <= `UCV_R_VECTOR;
            current_irq_latch <= `UCV_R_CUR_IRQ;
            mode_ptr_q  <= 2'd1;
            rx_cnt_q    <= 4'd0;
            rx_rd_q     <= 3'd0;
            rx_wr_q     <= 3'd0;
            tx_cnt_q    <= 4'd0;
            tx_rd_q     <= 3'd0;
            tx_wr_q     <= 3'd0;
            blk_err_q   <= 3'b000;
            overrun_q   <= 1'b0;
            rx_enabled  <= 1'b0;
            tx_enabled  <= 1'b0;
            ack_sync_q  <= 3'b111;
            cts_sync_q  <= 3'b111;
            ack_st_q    <= ST_IDLE;
            ack_cnt_q   <= 2'd0;
            xfer_ack_out_n <= 1'b1;
            data_out    <= 8'h00;
            data_oe     <= 1'b0;
            prdata      <= 32'h0;
        end else if (clk_en) begin
            ack_sync_q <= {ack_sync_q[1:0], int_ack_in_n};
            cts_sync_q <= {cts_sync_q[1:0], cts_in_n};
            prdata <= {24'h0, rd_byte};
            // Mode pointer and mode registers.
            if (mode_acc) begin
                if (pwrite) begin
                    case (mode_ptr_q)
                        2'd0:    mode_zero_watchdog_fill <= {wd[7:4], 4'h0};
                        2'd1:    mode_one_char_format    <= wd;
                        default: mode_two_channel_stop   <= wd;
                    endcase
                end
                if (mode_ptr_q != 2'd2)
                    mode_ptr_q <= mode_ptr_q + 2'd1;
            end
            if (wr_acc) begin
                case (paddr)
                    `UCV_A_CLKSEL:   clksel_q          <= wd;
                    `UCV_A_AUX:      auxiliary_control <= wd;
                    `UCV_A_IRQ_CTRL: irq_control_reg   <= wd;
                    `UCV_A_VECTOR:   vector_base_reg   <= wd;
                    default: ;
                endcase
            end
            // Commands.
            if (cmd_wr) begin
                if (wd[3])
                    tx_enabled <= 1'b0;
                else if (wd[2])
                    tx_enabled <= 1'b1;
                if (wd[1])
                    rx_enabled <= 1'b0;
                else if (wd[0])
                    rx_enabled <= 1'b1;
                case (cmd)
                    `UCV_C_RST_PTR:  mode_ptr_q <= 2'd1;
                    `UCV_C_PTR_ZERO: mode_ptr_q <= 2'd0;
                    `UCV_C_RST_TX:   tx_enabled <= 1'b0;
                    `UCV_C_RST_RX:   rx_enabled <= 1'b0;
                    `UCV_C_UPD_CIR:  current_irq_latch <= {rx_cnt_q[2:0], 3'b000,
                                                           CHAN_NUM};
                    default: ;
                endcase
            end
            // Receive FIFO.
            if (rx_rst) begin
                rx_cnt_q <= 4'd0;
                rx_rd_q  <= 3'd0;
                rx_wr_q  <= 3'd0;
            end else begin
                if (rx_push) begin
                    rx_mem[rx_wr_q]     <= rx_char;
                    rx_err_mem[rx_wr_q] <= rx_char_err;
                    rx_wr_q <= rx_wr_q + 3'd1;
                end
                if (rx_pop)
                    rx_rd_q <= rx_rd_q + 3'd1;
                rx_cnt_q <= rx_cnt_q + {3'b000, rx_push} - {3'b000, rx_pop};
            end
            // Error flags: set wins over clear.
            if (cmd_wr && (cmd == `UCV_C_RST_ERR || cmd == `UCV_C_RST_RX)) begin
                blk_err_q <= (blk_mode & rx_push) ? rx_char_err : 3'b000;
                overrun_q <= rx_char_valid & rx_enabled & (rx_cnt_q == DEPTH);
            end else begin
                if (blk_mode && rx_push)
                    blk_err_q <= blk_err_q | rx_char_err;
                if (rx_char_valid && rx_enabled && rx_cnt_q == DEPTH)
                    overrun_q <= 1'b1;
            end
            // Transmit FIFO.
            if (tx_rst) begin
                tx_cnt_q <= 4'd0;
                tx_rd_q  <= 3'd0;
                tx_wr_q  <= 3'd0;
            end else begin
                if (tx_push) begin
                    tx_mem[tx_wr_q] <= wd;
                    tx_wr_q <= tx_wr_q + 3'd1;
                end
                if (tx_pop)
                    tx_rd_q <= tx_rd_q + 3'd1;
                tx_cnt_q <= tx_cnt_q + {3'b000, tx_push} - {3'b000, tx_pop};
            end
            // Interrupt acknowledge cycle.
            case (ack_st_q)
                ST_IDLE: begin
                    xfer_ack_out_n <= 1'b1;
                    if (ack_fall) begin
                        current_irq_latch <= {rx_cnt_q[2:0], 3'b000, CHAN_NUM};
                        ack_st_q  <= ST_ACK;
                        ack_cnt_q <= 2'd0;
                    end
                end
                ST_ACK: begin
                    data_out <= vec;
                    data_oe  <= (irq_control_reg[1:0] != `UCV_VF_NONE);
                    xfer_ack_out_n <= 1'b0;
                    if (ack_cnt_q == `UCV_ACK_CYC) begin
                        xfer_ack_out_n <= 1'b1;
                        if (ack_sync_q[1] && ack_sync_q[2]) begin
                            data_oe  <= 1'b0;
                            ack_st_q <= ST_IDLE;
                        end
                    end else begin
                        ack_cnt_q <= ack_cnt_q + 2'd1;
                    end
                end
                default: ack_st_q <= ST_IDLE;
            endcase
        end
    end

endmodule // ucv_channel
`default_nettype wire

// ==== ucv_channel_props.sv ====
// Concurrent checks on the ports of the serial channel block.
`timescale 1ns/10ps
`default_nettype none
`include "ucv_defs.vh"

module ucv_channel_props (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        clk_en,
    // APB requests
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    // Acknowledge pins
    input wire logic        int_ack_in_n,
    input wire logic        xfer_ack_out_n,
    input wire logic        data_oe,
    // Channel state
    input wire logic        tx_char_valid,
    input wire logic [3:0]  data_bits,
    input wire logic [5:0]  stop_sixteenths,
    input wire logic        baud_set2,
    input wire logic        rx_enabled,
    input wire logic        tx_enabled
);
    ////////////////////////////////////////////////////////////////////////////
    logic [1:0] fmt_q;
    wire        wr_go = psel && penable && pwrite;

    // Shadow of the vector format field.
    always @(posedge core_clk)
        if (reset) fmt_q <= 2'b00;
        else if (clk_en && wr_go && paddr == `UCV_A_IRQ_CTRL) fmt_q <= pwdata[1:0];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset || !clk_en);

    ////////////////////////////////////////////////////////////////////////////
    property p_ack_len;
        $fell(xfer_ack_out_n) |-> (!xfer_ack_out_n) [*2] ##1 xfer_ack_out_n;
    endproperty
    a_ack_len: assert property (p_ack_len) else $error("ack pulse width wrong");
    property p_ack_after_req;
        $fell(int_ack_in_n) |-> ##[2:8] $fell(xfer_ack_out_n);
    endproperty
    a_ack_after_req: assert property (p_ack_after_req) else $error("no ack pulse");
    property p_oe_with_ack;
        $rose(data_oe) |-> $fell(xfer_ack_out_n) && !int_ack_in_n;
    endproperty
    a_oe_with_ack: assert property (p_oe_with_ack) else $error("vector off ack");
    property p_oe_release;
        $rose(int_ack_in_n) |-> ##[1:8] !data_oe;
    endproperty
    a_oe_release: assert property (p_oe_release) else $error("bus not released");
    property p_no_vector;
        fmt_q == `UCV_VF_NONE |-> !data_oe;
    endproperty
    a_no_vector: assert property (p_no_vector) else $error("bus driven in format 11");
    property p_tx_refuse;
        wr_go && paddr == `UCV_A_TXD_RXD && !tx_enabled && !tx_char_valid |=> !tx_char_valid;
    endproperty
    a_tx_refuse: assert property (p_tx_refuse) else $error("disabled tx loaded");
    property p_tx_on;
        wr_go && paddr == `UCV_A_CMD_STAT && pwdata[2] && !pwdata[3] |=> tx_enabled;
    endproperty
    a_tx_on: assert property (p_tx_on) else $error("tx enable ignored");
    property p_rx_off;
        wr_go && paddr == `UCV_A_CMD_STAT && pwdata[1] |=> !rx_enabled;
    endproperty
    a_rx_off: assert property (p_rx_off) else $error("rx disable ignored");
    property p_baud;
        wr_go && paddr == `UCV_A_AUX |=> baud_set2 == $past(pwdata[`UCV_AUX_BRG_SET]);
    endproperty
    a_baud: assert property (p_baud) else $error("rate set select wrong");
    property p_stop_five;
        stop_sixteenths >= 6'd17 && stop_sixteenths <= 6'd24 |-> data_bits == 4'd5;
    endproperty
    a_stop_five: assert property (p_stop_five) else $error("half bit added wrongly");
endmodule // ucv_channel_props
`default_nettype wire

// ==== ucv_host.sv ====
// Host side model that runs interrupt acknowledge cycles.
`timescale 1ns/10ps
`default_nettype none

module ucv_host (
    // Clock
    input  wire logic       core_clk,
    // Acknowledge pins
    output var  logic       int_ack_in_n,
    input  wire logic       xfer_ack_out_n,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] last_q = 8'h00;
    // A released bus shows a changing pattern, the inverse of its value one cycle before.
    wire  [7:0] data_bus = data_oe ? data_out : ~last_q;

    initial int_ack_in_n = 1'b1;

    always @(posedge core_clk) last_q <= data_bus;

    // One acknowledge cycle; the pin is held low until the pulse has ended.
    task automatic ack_cycle(output logic [7:0] vec, output logic oe, output logic seen);
        integer n;
        begin
            seen = 1'b0;
            @(posedge core_clk) int_ack_in_n <= 1'b0;
            for (n = 0; n < 16 && !seen; n = n + 1) begin
                @(posedge core_clk);
                seen = (xfer_ack_out_n === 1'b0);
            end
            vec = data_bus;
            oe = data_oe;
            for (n = 0; n < 16 && xfer_ack_out_n !== 1'b1; n = n + 1) @(posedge core_clk);
            int_ack_in_n <= 1'b1;
            repeat (8) @(posedge core_clk);
        end
    endtask
endmodule // ucv_host
`default_nettype wire

// ==== uart_channel_config_and_vector_tb.sv ====
// Self-checking bench for the serial channel configuration and vector logic.
`timescale 1ns/10ps
`default_nettype none
`include "ucv_defs.vh"

bind ucv_channel ucv_channel_props i_props (.core_clk, .reset, .clk_en, .psel, .penable,
    .pwrite, .paddr, .pwdata, .int_ack_in_n, .xfer_ack_out_n, .data_oe, .tx_char_valid,
    .data_bits, .stop_sixteenths, .baud_set2, .rx_enabled, .tx_enabled);

module uart_channel_config_and_vector_tb;
    localparam [1:0] CH = 2'd2;
    logic        core_clk      = 1'b0;
    logic        reset         = 1'b1;
    logic        psel          = 1'b0;
    logic        penable       = 1'b0;
    logic        pwrite        = 1'b0;
    logic [7:0]  paddr         = 8'h00;
    logic [31:0] pwdata        = 32'h0;
    logic        rx_char_valid = 1'b0;
    logic [7:0]  rx_char       = 8'h00;
    logic [2:0]  rx_char_err   = 3'h0;
    logic        tx_char_ready = 1'b0;
    logic        cts_in_n      = 1'b0;
    logic [31:0] rd;
    integer      num_errors    = 0;
    integer      total_checks  = 0;
    wire  [31:0] prdata;
    wire  [7:0]  data_out, tx_char, rx_tx_clock_select;
    wire  [3:0]  data_bits;
    wire  [5:0]  stop_sixteenths;
    wire  [1:0]  parity_mode, channel_mode;
    wire         pready, pslverr, int_ack_in_n, xfer_ack_out_n, data_oe, tx_char_valid;
    wire         parity_odd, watchdog_en, baud_set2, rx_enabled, tx_enabled, rx_bid, tx_bid;

    always #4 core_clk = ~core_clk;

    ucv_channel #(.CHAN_NUM(CH)) i_dut (.core_clk, .reset, .clk_en(1'b1), .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .int_ack_in_n, .xfer_ack_out_n,
        .data_out, .data_oe, .cts_in_n, .rx_char_valid, .rx_char, .rx_char_err,
        .tx_char_ready, .tx_char_valid, .tx_char, .data_bits, .parity_mode, .parity_odd,
        .channel_mode, .stop_sixteenths, .watchdog_en, .baud_set2, .rx_tx_clock_select,
        .rx_enabled, .tx_enabled, .rx_bid, .tx_bid);

    ucv_host i_host (.core_clk, .int_ack_in_n, .xfer_ack_out_n, .data_out, .data_oe);

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        @(posedge core_clk);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, what);
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_vals;
        rdchk(`UCV_A_VECTOR, 32'h0f, "vector reset");
        wr(`UCV_A_CUR_IRQ, 32'h00);
        rdchk(`UCV_A_CUR_IRQ, 32'hff, "current irq reset");
        wr(8'h24, 32'h5a);
        rdchk(8'h24, 32'h0, "unmapped");
        chk(pslverr, 0, "slave error");
    endtask

    task automatic t_modes;
        integer i, j;
        logic [3:0] sc;
        for (i = 0; i < 4; i = i + 1) begin
            wr(`UCV_A_CMD_STAT, {`UCV_C_RST_PTR, 4'h0});
            wr(`UCV_A_MODE, {24'h0, 3'b000, i[1:0], i[0], i[1:0]});
            chk(data_bits, i + 5, "char length");
            chk({parity_mode, parity_odd}, {i[1:0], i[0]}, "parity");
            for (j = 0; j < 2; j = j + 1) begin
                sc = 4'd4 + {2'b00, i[1:0]} + (j ? 4'd8 : 4'd0);
                wr(`UCV_A_MODE, {24'h0, i[1:0], 2'b00, sc});
                chk(channel_mode, i, "channel mode");
                chk(stop_sixteenths, 9 + sc + (sc > 4'd7 ? 8 : 0) + ((sc <= 4'd7 && i == 0) ? 8 : 0),
                    "stop length");
            end
        end
    endtask

    task automatic t_mode_zero;
        integer i;
        for (i = 0; i < 2; i = i + 1) begin
            wr(`UCV_A_CMD_STAT, {`UCV_C_PTR_ZERO, 4'h0});
            wr(`UCV_A_MODE, i ? 32'h05 : 32'h8a);
            chk(watchdog_en, i == 0, "watchdog enable");
            wr(`UCV_A_CMD_STAT, {`UCV_C_PTR_ZERO, 4'h0});
            rdchk(`UCV_A_MODE, i ? 32'h0f : 32'h8f, "mode zero readback");
        end
    endtask

    task automatic t_aux;
        wr(`UCV_A_AUX, 32'h80);
        chk(baud_set2, 1, "second rate set");
        wr(`UCV_A_AUX, 32'h7f);
        chk(baud_set2, 0, "first rate set");
        rdchk(`UCV_A_AUX, 32'h7f, "aux readback");
        wr(`UCV_A_CLKSEL, 32'h5a);
        chk(rx_tx_clock_select, 32'h5a, "clock select");
    endtask

    task automatic t_tx;
        wr(`UCV_A_CMD_STAT, 32'h0a);
        chk({tx_enabled, rx_enabled}, 0, "both disabled");
        wr(`UCV_A_TXD_RXD, 32'h11);
        chk(tx_char_valid, 0, "load refused");
        wr(`UCV_A_CMD_STAT, 32'h05);
        chk({tx_enabled, rx_enabled}, 2'b11, "both enabled");
        rdchk(`UCV_A_FMT, 32'hc0, "enable status");
        chk(tx_bid, 1, "tx bid when empty");
        wr(`UCV_A_TXD_RXD, 32'h3c);
        chk({tx_char_valid, tx_char}, 9'h13c, "tx character");
        chk(tx_bid, 0, "tx bid withdrawn");
        @(posedge core_clk) tx_char_ready <= 1'b1;
        @(posedge core_clk) tx_char_ready <= 1'b0;
        @(posedge core_clk);
        chk(tx_char_valid, 0, "tx drained");
    endtask

    task automatic t_rx;
        wr(`UCV_A_CMD_STAT, {`UCV_C_RST_PTR, 4'h0});
        wr(`UCV_A_MODE, 32'h23);
        @(posedge core_clk);
        rx_char_valid <= 1'b1;
        rx_char       <= 8'h96;
        rx_char_err   <= 3'b010;
        @(posedge core_clk) rx_char_valid <= 1'b0;
        @(posedge core_clk);
        chk(rx_bid, 1, "rx bid one byte");
        apb(1'b0, `UCV_A_CMD_STAT, 32'h0);
        chk({rd[7:5], rd[1:0]}, 5'b01001, "status with char");
        wr(`UCV_A_CMD_STAT, {`UCV_C_UPD_CIR, 4'h0});
        rdchk(`UCV_A_CUR_IRQ, {24'h0, 3'b001, 3'b000, CH}, "current irq");
        rdchk(`UCV_A_TXD_RXD, 32'h96, "rx data");
        apb(1'b0, `UCV_A_CMD_STAT, 32'h0);
        chk({rd[7:5], rd[0]}, 4'b0100, "block error held");
        chk(rx_bid, 0, "rx bid empty");
        wr(`UCV_A_CMD_STAT, {`UCV_C_RST_ERR, 4'h0});
        apb(1'b0, `UCV_A_CMD_STAT, 32'h0);
        chk(rd[7:5], 0, "error reset");
        cts_in_n <= 1'b1;
        wr(`UCV_A_MODE, 32'h10);
        wr(`UCV_A_TXD_RXD, 32'h77);
        chk(tx_char_valid, 0, "held by cts");
        cts_in_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk(tx_char_valid, 1, "cts released");
    endtask

    task automatic t_vectors;
        integer i;
        logic [7:0] v, e;
        logic oe, seen;
        wr(`UCV_A_VECTOR, 32'ha5);
        for (i = 0; i < 4; i = i + 1) begin
            e = (i == 0) ? 8'ha5 : (i == 1) ? {6'b101001, CH} : {3'b101, 3'b000, CH};
            wr(`UCV_A_IRQ_CTRL, i);
            i_host.ack_cycle(v, oe, seen);
            chk(seen, 1, "ack pulse");
            chk(oe, i != 3, "bus drive");
            if (i != 3) chk(v, e, "vector byte");
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        t_reset_vals;
        t_modes;
        t_mode_zero;
        t_aux;
        t_tx;
        t_rx;
        t_vectors;
        complete_run;
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors = num_errors + 1;
        complete_run;
    end
endmodule // uart_channel_config_and_vector_tb
`default_nettype wire
